// File: hw/capture_channel.sv
`timescale 1ns/1ps
module capture_channel (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Trigger and counter
  input  wire logic                          trig,
  input  wire logic [timer_pkg::CNT_W-1:0]   count,
  // Register accesses
  input  wire logic                          status_rd,
  input  wire logic                          hi_rd,
  input  wire logic                          lo_rd,
  input  wire logic                          lo_access,
  // State
  output logic      [timer_pkg::CNT_W-1:0]   value,
  output logic                               flag
);
  import timer_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] value;
    logic             flag;
    logic             armed;
    logic             locked;
  } cap_state_t;

  cap_state_t st_q;
  cap_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (status_rd && st_q.flag) begin
      st_d.armed = 1'b1;
    end
    if (lo_access && st_q.armed) begin
      st_d.flag  = 1'b0;
      st_d.armed = 1'b0;
    end
    if (hi_rd) begin
      st_d.locked = 1'b1;
    end
    if (lo_rd) begin
      st_d.locked = 1'b0;
    end
    // A capture in the clearing cycle keeps the flag set
    if (trig && !st_q.locked) begin
      st_d.value = count;
      st_d.flag  = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{value: CAP_RESET, flag: 1'b0, armed: 1'b0, locked: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.value;
  assign flag  = st_q.flag;

  a_capture_load: assert property (@(posedge clk) disable iff (rst)
    trig && !st_q.locked |=> value == $past(count) && flag)
    else $error("capture did not load the count");

  a_capture_blocked: assert property (@(posedge clk) disable iff (rst)
    st_q.locked && !lo_rd |=> $stable(value) && !$rose(flag)
    && (flag || !$past(flag) || $past(lo_access)))
    else $error("capture changed while channel locked");

  c_capture_seen: cover property (@(posedge clk) disable iff (rst) trig && !st_q.locked);

endmodule : capture_channel

// File: hw/free_timer.sv
`timescale 1ns/1ps
// Functional notes
// - Counter advances once per timer tick: CPU clock divided by 2, 4 or 8.
// - Both clock select bits one takes counting from the external clock pin.
// - External edge select picks rising or falling pin transition as count edge.
// - External counting is resynchronised to the CPU clock before use.
// - Counter resets to FFFC; no other reload value is ever used.
// - Writing low byte of either counter view forces the counter to FFFC.
// - Alternate view matches main view; its low read never clears overflow flag.
// - Software reads high byte first; that read latches the low byte.
// - Latched low byte stays frozen until the low read ends the sequence.
// - Low read outside a sequence returns the live low byte.
// - Overflow flag sets when counter wraps from FFFF to 0000.
// - Overflow request asserts when enabled and CPU mask clear; otherwise pending.
// - Overflow flag clears after status read seeing it, then main low access.
// - Counting continues in wait; halt freezes count until released.
// - Timer input on an unbonded pin always reads as one.
// - Active capture edge copies the counter into that channel's capture register.
// - Capture sets channel flag; shared enable and clear mask raise request.
// - Capture flag clears after status read seeing it, then capture low access.
// - Reading capture high byte blocks captures until capture low byte read.
// - In one-pulse and PWM modes only the second capture channel works.
// - Capture pins feed capture logic; the high-read lock stops it, and one-pulse or PWM mode stops channel one.
module free_timer #(
  parameter bit EXT_BONDED  = 1'b1,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1
) (
  // Clock and reset
  input  wire logic                            CLK,
  input  wire logic                            SYS_RST,
  // APB slave
  input  wire logic                            PSEL,
  input  wire logic                            PENABLE,
  input  wire logic                            PWRITE,
  input  wire logic [timer_pkg::ADDR_W-1:0]    PADDR,
  input  wire logic [timer_pkg::DATA_W-1:0]    PWDATA,
  output logic      [timer_pkg::DATA_W-1:0]    PRDATA,
  output logic                                 PREADY,
  output logic                                 PSLVERR,
  // Timer pins
  input  wire logic                            EXT_CLOCK_PIN,
  input  wire logic                            CAPTURE_PIN_ONE,
  input  wire logic                            CAPTURE_PIN_TWO,
  // CPU side
  input  wire logic                            CPU_IRQ_MASK,
  input  wire logic                            HALT_MODE,
  output logic                                 TIMER_IRQ
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0]        ctrl_one;
    logic [7:0]        ctrl_two;
    logic [CNT_W-1:0]  count;
    logic [DIV_W-1:0]  prescale;
    logic [7:0]        low_buf;
    logic              low_held;
    logic              ovf_flag;
    logic              ovf_armed;
    logic              ack;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } timer_state_t;

  timer_state_t st_q;
  timer_state_t st_d;

  logic             access;
  logic             rd_take;
  logic             wr_take;
  logic             any_take;
  logic             mapped;
  logic             rd_status;
  logic             rd_cnt_hi;
  logic             rd_cnt_lo;
  logic             main_lo_access;
  logic             cnt_lo_write;
  logic [1:0]       clk_sel;
  logic             halt_sync;
  logic             halt_meta;
  logic             mask_meta;
  logic             mask_sync;
  logic             ext_rise;
  logic             ext_fall;
  logic             cap1_rise;
  logic             cap1_fall;
  logic             cap2_rise;
  logic             cap2_fall;
  logic             ext_edge;
  logic             tick;
  logic             wrap;
  logic             cap1_trig;
  logic             cap2_trig;
  logic             cap1_enable;
  logic [CNT_W-1:0] cap1_value;
  logic [CNT_W-1:0] cap2_value;
  logic             cap1_flag;
  logic             cap2_flag;
  logic [7:0]       status_byte;
  logic [7:0]       rd_byte;

  // Unbonded pins read as one
  pin_sync u_ext_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .pin  (EXT_BONDED ? EXT_CLOCK_PIN : 1'b1),
    .rise (ext_rise),
    .fall (ext_fall)
  );

  pin_sync u_cap1_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .pin  (CAP1_BONDED ? CAPTURE_PIN_ONE : 1'b1),
    .rise (cap1_rise),
    .fall (cap1_fall)
  );

  pin_sync u_cap2_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .pin  (CAP2_BONDED ? CAPTURE_PIN_TWO : 1'b1),
    .rise (cap2_rise),
    .fall (cap2_fall)
  );

  // Halt and CPU mask come from another block; synchronise them as levels
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
      mask_meta <= 1'b1;
      mask_sync <= 1'b1;
    end else begin
      halt_meta <= HALT_MODE;
      halt_sync <= halt_meta;
      mask_meta <= CPU_IRQ_MASK;
      mask_sync <= mask_meta;
    end
  end

  // APB decode; one wait state, read data sampled in the first access cycle
  assign access         = PSEL & PENABLE;
  assign PREADY         = access & st_q.ack;
  assign rd_take        = access & ~st_q.ack & ~PWRITE;
  assign wr_take        = PREADY & PWRITE;
  assign any_take       = rd_take | wr_take;
  assign rd_status      = rd_take && PADDR == ADDR_STATUS;
  assign rd_cnt_hi      = rd_take && (PADDR == ADDR_CNT_HI || PADDR == ADDR_ALT_HI);
  assign rd_cnt_lo      = rd_take && (PADDR == ADDR_CNT_LO || PADDR == ADDR_ALT_LO);
  assign main_lo_access = any_take && PADDR == ADDR_CNT_LO;
  assign cnt_lo_write   = wr_take && (PADDR == ADDR_CNT_LO || PADDR == ADDR_ALT_LO);

  always_comb begin
    case (PADDR)
      ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_STATUS,
      ADDR_CNT_HI, ADDR_CNT_LO, ADDR_ALT_HI, ADDR_ALT_LO,
      ADDR_CAP1_HI, ADDR_CAP1_LO, ADDR_CAP2_HI, ADDR_CAP2_LO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Timer tick selection
  assign clk_sel  = st_q.ctrl_two[C2_CLK_SEL +: 2];
  // Pin edges arrive already retimed to CLK, so one count per edge
  assign ext_edge = st_q.ctrl_two[C2_EXT_EDGE] ? ext_rise : ext_fall;

  always_comb begin
    case (clk_sel)
      CLK_DIV2: tick = st_q.prescale[0];
      CLK_DIV4: tick = &st_q.prescale[1:0];
      CLK_DIV8: tick = &st_q.prescale;
      CLK_EXT:  tick = ext_edge;
      default:  tick = 1'b0;
    endcase
    if (halt_sync) begin
      tick = 1'b0;
    end
  end

  assign wrap = tick && st_q.count == COUNT_TOP;

  // Capture triggers
  assign cap1_enable = ~(st_q.ctrl_two[C2_ONE_PULSE] | st_q.ctrl_two[C2_PWM_MODE]);
  assign cap1_trig   = cap1_enable &
                       (st_q.ctrl_one[C1_CAP_EDGE_1] ? cap1_rise : cap1_fall);
  assign cap2_trig   = st_q.ctrl_two[C2_CAP_EDGE_2] ? cap2_rise : cap2_fall;

  capture_channel u_cap1 (
    .clk       (CLK),
    .rst       (SYS_RST),
    .trig      (cap1_trig),
    .count     (st_q.count),
    .status_rd (rd_status),
    .hi_rd     (rd_take && PADDR == ADDR_CAP1_HI),
    .lo_rd     (rd_take && PADDR == ADDR_CAP1_LO),
    .lo_access (any_take && PADDR == ADDR_CAP1_LO),
    .value     (cap1_value),
    .flag      (cap1_flag)
  );

  capture_channel u_cap2 (
    .clk       (CLK),
    .rst       (SYS_RST),
    .trig      (cap2_trig),
    .count     (st_q.count),
    .status_rd (rd_status),
    .hi_rd     (rd_take && PADDR == ADDR_CAP2_HI),
    .lo_rd     (rd_take && PADDR == ADDR_CAP2_LO),
    .lo_access (any_take && PADDR == ADDR_CAP2_LO),
    .value     (cap2_value),
    .flag      (cap2_flag)
  );

  always_comb begin
    status_byte                = 8'h00;
    status_byte[ST_CAP_FLAG_1] = cap1_flag;
    status_byte[ST_CAP_FLAG_2] = cap2_flag;
    status_byte[ST_OVF_FLAG]   = st_q.ovf_flag;
  end

  // Read mux
  always_comb begin
    case (PADDR)
      ADDR_CTRL_ONE: rd_byte = st_q.ctrl_one;
      ADDR_CTRL_TWO: rd_byte = st_q.ctrl_two;
      ADDR_STATUS:   rd_byte = status_byte;
      ADDR_CNT_HI,
      ADDR_ALT_HI:   rd_byte = st_q.count[15:8];
      ADDR_CNT_LO,
      ADDR_ALT_LO:   rd_byte = st_q.low_held ? st_q.low_buf : st_q.count[7:0];
      ADDR_CAP1_HI:  rd_byte = cap1_value[15:8];
      ADDR_CAP1_LO:  rd_byte = cap1_value[7:0];
      ADDR_CAP2_HI:  rd_byte = cap2_value[15:8];
      ADDR_CAP2_LO:  rd_byte = cap2_value[7:0];
      default:       rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    st_d          = st_q;
    st_d.prescale = st_q.prescale + 3'h1;
    // Bus handshake
    if (rd_take || (access && PWRITE && !st_q.ack)) begin
      st_d.ack     = 1'b1;
      st_d.pslverr = ~mapped;
    end
    if (PREADY) begin
      st_d.ack = 1'b0;
    end
    if (rd_take) begin
      st_d.prdata = {24'h000000, rd_byte};
    end
    if (wr_take && PADDR == ADDR_CTRL_ONE) begin
      st_d.ctrl_one = PWDATA[7:0] & C1_WR_MASK;
    end
    if (wr_take && PADDR == ADDR_CTRL_TWO) begin
      st_d.ctrl_two = PWDATA[7:0] & C2_WR_MASK;
    end
    // Coherent two-byte read
    if (rd_cnt_hi && !st_q.low_held) begin
      st_d.low_buf  = st_q.count[7:0];
      st_d.low_held = 1'b1;
    end
    if (rd_cnt_lo) begin
      st_d.low_held = 1'b0;
    end
    // Counter
    if (tick) begin
      st_d.count = st_q.count + 16'h0001;
    end
    if (cnt_lo_write) begin
      st_d.count = COUNT_RESET;
    end
    // Overflow flag, two-step clear, set wins
    if (rd_status && st_q.ovf_flag) begin
      st_d.ovf_armed = 1'b1;
    end
    if (main_lo_access && st_q.ovf_armed) begin
      st_d.ovf_flag  = 1'b0;
      st_d.ovf_armed = 1'b0;
    end
    if (wrap) begin
      st_d.ovf_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= '{ctrl_one: CTRL_RESET, ctrl_two: CTRL_RESET,
                count: COUNT_RESET, prescale: '0, low_buf: 8'h00,
                low_held: 1'b0, ovf_flag: 1'b0, ovf_armed: 1'b0,
                ack: 1'b0, prdata: '0, pslverr: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign PRDATA  = st_q.prdata;
  assign PSLVERR = st_q.pslverr & PREADY;
  // Requests stay pending in the flags until enable and mask allow them
  assign TIMER_IRQ = ~mask_sync &
                     ((st_q.ovf_flag & st_q.ctrl_one[C1_OVF_IRQ_EN]) |
                      ((cap1_flag | cap2_flag) & st_q.ctrl_one[C1_CAP_IRQ_EN]));

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_ovf_on_wrap: assert property (wrap |=> st_q.ovf_flag && st_q.count == 16'h0000)
    else $error("wrap did not set overflow flag");

  a_count_reload: assert property (cnt_lo_write |=> st_q.count == COUNT_RESET)
    else $error("low byte write did not reload counter");

  a_div8_spacing: assert property (clk_sel == CLK_DIV8 && tick && !halt_sync
    ##1 clk_sel == CLK_DIV8 |-> (!tick || clk_sel != CLK_DIV8) [*7])
    else $error("divide by 8 tick spacing wrong");

  a_halt_holds: assert property (halt_sync && !cnt_lo_write |=> $stable(st_q.count))
    else $error("counter moved in halt");

  a_high_latch: assert property (rd_cnt_hi && !st_q.low_held
    |=> st_q.low_held && st_q.low_buf == $past(st_q.count[7:0]))
    else $error("high read did not latch low byte");

  a_low_frozen: assert property (st_q.low_held && !rd_cnt_lo |=> $stable(st_q.low_buf))
    else $error("latched low byte changed");

  a_ovf_clear_order: assert property ($fell(st_q.ovf_flag) |-> $past(st_q.ovf_armed)
    && $past(main_lo_access))
    else $error("overflow flag cleared out of order");

  a_alt_keeps_ovf: assert property (st_q.ovf_flag && !main_lo_access |=> st_q.ovf_flag)
    else $error("overflow flag lost without main low access");

  a_irq_pending: assert property (st_q.ovf_flag && st_q.ctrl_one[C1_OVF_IRQ_EN]
    && !mask_sync |-> TIMER_IRQ)
    else $error("overflow request not raised");

  a_cap1_mode_off: assert property (!cap1_enable |=> $stable(cap1_value))
    else $error("channel one captured in pulse mode");

  c_wrap_seen: cover property (wrap);
  c_coherent_read: cover property (rd_cnt_hi ##[1:20] rd_cnt_lo);
  c_ext_count: cover property (clk_sel == CLK_EXT && tick);

endmodule : free_timer

// File: hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and edge pulses
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  import timer_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  // Idle level high matches an unbonded pin
  always_comb begin
    st_d      = st_q;
    st_d.meta = pin;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= 3'h7;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = st_q.sync & ~st_q.prev;
  assign fall = ~st_q.sync & st_q.prev;

endmodule : pin_sync

// File: include/timer_pkg.sv
package timer_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned DIV_W  = 3;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ALT_HI   = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_ALT_LO   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CAP1_HI  = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_CAP1_LO  = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CAP2_HI  = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_CAP2_LO  = 8'h28;

  // timer_control_one fields
  localparam int unsigned C1_CAP_IRQ_EN  = 7;
  localparam int unsigned C1_OVF_IRQ_EN  = 5;
  localparam int unsigned C1_CAP_EDGE_1  = 1;
  localparam logic [7:0]  C1_WR_MASK     = 8'hA2;
  // timer_control_two fields
  localparam int unsigned C2_ONE_PULSE   = 7;
  localparam int unsigned C2_PWM_MODE    = 6;
  localparam int unsigned C2_CLK_SEL     = 2;
  localparam int unsigned C2_CAP_EDGE_2  = 1;
  localparam int unsigned C2_EXT_EDGE    = 0;
  localparam logic [7:0]  C2_WR_MASK     = 8'hCF;
  // timer_status fields
  localparam int unsigned ST_CAP_FLAG_1  = 7;
  localparam int unsigned ST_CAP_FLAG_2  = 6;
  localparam int unsigned ST_OVF_FLAG    = 5;

  // Reset values and counter top
  localparam logic [7:0]       CTRL_RESET  = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'hFFFC;
  localparam logic [CNT_W-1:0] COUNT_TOP   = 16'hFFFF;
  localparam logic [CNT_W-1:0] CAP_RESET   = 16'h0000;

  // Clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

endpackage : timer_pkg

// File: testbench/free_timer_tb.sv
`timescale 1ns/1ps
module free_timer_tb;
  import timer_pkg::*;

  logic              clk;
  logic              sys_rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              ext_pin;
  logic              cap_one;
  logic              cap_two;
  logic              irq_mask;
  logic              halt;
  logic              timer_irq;
  logic [DATA_W-1:0] rdata;
  logic              rerr;
  int                num_errors  = 0;
  int                check_count = 0;
  int                cycles      = 0;

  free_timer u_free_timer (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_CLOCK_PIN(ext_pin), .CAPTURE_PIN_ONE(cap_one), .CAPTURE_PIN_TWO(cap_two),
    .CPU_IRQ_MASK(irq_mask), .HALT_MODE(halt), .TIMER_IRQ(timer_irq)
  );

  pin_model u_pin_model (
    .clk(clk), .ext_clock_pin(ext_pin), .capture_pin_one(cap_one), .capture_pin_two(cap_two)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Request is held until pready is sampled high at a rising edge, released at that edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(n, 32'd2, "apb wait states");
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string what);
    apb(1'b0, a, '0);
    chk(rdata & {24'h0, m}, {24'h0, e}, what);
  endtask : rdchk

  // High byte first, low byte at the next word
  task automatic rd16(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    apb(1'b0, a, '0);
    v[15:8] = rdata[7:0];
    apb(1'b0, a + 8'h04, '0);
    v[7:0] = rdata[7:0];
  endtask : rd16

  task automatic cnt_is(input logic [15:0] e);
    logic [15:0] v;
    rd16(ADDR_ALT_HI, v);
    chk({16'h0, v}, {16'h0, e}, "count");
  endtask : cnt_is

  task automatic irq_is(input logic e);
    @(negedge clk);
    chk({31'h0, timer_irq}, {31'h0, e}, "irq");
  endtask : irq_is

  task automatic test_reset();
    logic [15:0] v;
    rd16(ADDR_CNT_HI, v);
    chk({31'h0, v inside {16'hFFFC, 16'hFFFD}}, 32'h1, "count after reset");
    rdchk(ADDR_CTRL_ONE, 8'hFF, 8'h00, "ctrl one reset");
    rdchk(ADDR_CTRL_TWO, 8'hFF, 8'h00, "ctrl two reset");
    rd16(ADDR_CAP1_HI, v);
    chk({16'h0, v}, 32'h0, "capture one reset");
    rd16(ADDR_CAP2_HI, v);
    chk({16'h0, v}, 32'h0, "capture two reset");
    apb(1'b0, 8'h2C, '0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    wr(ADDR_CTRL_ONE, 8'hFF);
    rdchk(ADDR_CTRL_ONE, 8'hFF, C1_WR_MASK, "ctrl one mask");
    wr(ADDR_CTRL_ONE, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_rates();
    logic [1:0]  code [3] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
    int          dv   [3] = '{2, 4, 8};
    logic [15:0] a;
    logic [15:0] b;
    int          d;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL_TWO, {4'h0, code[i], 2'h0});
      rd16(ADDR_ALT_HI, a);
      repeat (56) @(posedge clk);
      rd16(ADDR_ALT_HI, b);
      d = int'(16'(b - a));
      chk({31'h0, d >= 64 / dv[i] - 1 && d <= 64 / dv[i] + 1}, 32'h1, "rate");
    end
    $display("test_rates done");
  endtask : test_rates

  task automatic test_overflow();
    logic [15:0] v;
    irq_mask <= 1'b1;
    wr(ADDR_CTRL_ONE, 8'h20);
    wr(ADDR_CTRL_TWO, {4'h0, CLK_DIV2, 2'h0});
    apb(1'b0, ADDR_STATUS, '0);
    wr(ADDR_CNT_LO, 8'h00);
    rdchk(ADDR_STATUS, 8'h20, 8'h00, "write clears overflow");
    rd16(ADDR_ALT_HI, v);
    chk({31'h0, v >= 16'hFFFC}, 32'h1, "count forced");
    repeat (20) @(posedge clk);
    rdchk(ADDR_STATUS, 8'h20, 8'h20, "overflow set");
    irq_is(1'b0);
    irq_mask <= 1'b0;
    repeat (4) @(posedge clk);
    irq_is(1'b1);
    apb(1'b0, ADDR_ALT_LO, '0);
    rdchk(ADDR_STATUS, 8'h20, 8'h20, "alt low keeps flag");
    apb(1'b0, ADDR_CNT_LO, '0);
    rdchk(ADDR_STATUS, 8'h20, 8'h00, "overflow cleared");
    irq_is(1'b0);
    $display("test_overflow done");
  endtask : test_overflow

  task automatic test_latch();
    logic [15:0] v;
    logic [7:0]  d;
    apb(1'b0, ADDR_ALT_HI, '0);
    repeat (40) @(posedge clk);
    rd16(ADDR_ALT_HI, v);
    apb(1'b0, ADDR_ALT_LO, '0);
    d = rdata[7:0] - v[7:0];
    chk({31'h0, d >= 8'd24 && d <= 8'd28}, 32'h1, "low byte latch");
    $display("test_latch done");
  endtask : test_latch

  task automatic test_ext();
    wr(ADDR_CTRL_TWO, {4'h0, CLK_EXT, 2'h1});
    wr(ADDR_ALT_LO, 8'h00);
    cnt_is(16'hFFFC);
    u_pin_model.set_ext(1'b0, 4);
    cnt_is(16'hFFFC);
    u_pin_model.set_ext(1'b1, 4);
    cnt_is(16'hFFFD);
    wr(ADDR_CTRL_TWO, {4'h0, CLK_EXT, 2'h0});
    u_pin_model.set_ext(1'b0, 4);
    cnt_is(16'hFFFE);
    u_pin_model.set_ext(1'b1, 4);
    cnt_is(16'hFFFE);
    halt <= 1'b1;
    u_pin_model.set_ext(1'b0, 4);
    u_pin_model.set_ext(1'b1, 4);
    cnt_is(16'hFFFE);
    halt <= 1'b0;
    u_pin_model.set_ext(1'b0, 12);
    u_pin_model.set_ext(1'b1, 12);
    cnt_is(16'hFFFF);
    $display("test_ext done");
  endtask : test_ext

  task automatic test_capture();
    logic [15:0] v;
    wr(ADDR_CTRL_ONE, 8'h82);
    wr(ADDR_CTRL_TWO, {4'h0, CLK_EXT, 2'h3});
    u_pin_model.set_cap(1, 1'b0);
    u_pin_model.set_cap(1, 1'b1);
    u_pin_model.set_cap(2, 1'b0);
    rdchk(ADDR_STATUS, 8'hC0, 8'h80, "capture one flag");
    irq_is(1'b1);
    u_pin_model.set_cap(2, 1'b1);
    rdchk(ADDR_STATUS, 8'hC0, 8'hC0, "capture two flag");
    rd16(ADDR_CAP2_HI, v);
    chk({16'h0, v}, 32'hFFFF, "capture two value");
    rdchk(ADDR_CAP1_HI, 8'hFF, 8'hFF, "capture one high");
    u_pin_model.set_ext(1'b0, 4);
    u_pin_model.set_ext(1'b1, 4);
    u_pin_model.set_cap(1, 1'b0);
    u_pin_model.set_cap(1, 1'b1);
    rdchk(ADDR_CAP1_LO, 8'hFF, 8'hFF, "capture locked");
    rdchk(ADDR_STATUS, 8'hE0, 8'h20, "flags after lock");
    irq_is(1'b0);
    u_pin_model.set_cap(1, 1'b0);
    u_pin_model.set_cap(1, 1'b1);
    rdchk(ADDR_STATUS, 8'h80, 8'h80, "capture after unlock");
    rd16(ADDR_CAP1_HI, v);
    chk({16'h0, v}, 32'h0, "new capture value");
    $display("test_capture done");
  endtask : test_capture

  task automatic test_one_pulse();
    wr(ADDR_CTRL_TWO, {1'b1, 3'h0, CLK_EXT, 2'h1});
    u_pin_model.set_cap(1, 1'b0);
    u_pin_model.set_cap(1, 1'b1);
    u_pin_model.set_cap(2, 1'b1);
    u_pin_model.set_cap(2, 1'b0);
    rdchk(ADDR_STATUS, 8'hC0, 8'h40, "one pulse capture");
    $display("test_one_pulse done");
  endtask : test_one_pulse

  initial begin
    sys_rst  = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = '0;
    pwdata   = '0;
    irq_mask = 1'b0;
    halt     = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset();
    test_rates();
    test_overflow();
    test_latch();
    test_ext();
    test_capture();
    test_one_pulse();
    tally_and_finish();
  end
endmodule : free_timer_tb

// File: testbench/pin_model.sv
`timescale 1ns/1ps
module pin_model (
  // Clock
  input  wire logic clk,
  // Timer pins
  output logic      ext_clock_pin,
  output logic      capture_pin_one,
  output logic      capture_pin_two
);
  // Pins idle high, as an input with pull-up, so reset leaves no false edge
  initial begin
    ext_clock_pin   = 1'b1;
    capture_pin_one = 1'b1;
    capture_pin_two = 1'b1;
  end

  // Each edge is followed by a quiet gap of at least four CPU cycles
  task automatic set_ext(input logic lvl, input int gap);
    @(posedge clk);
    ext_clock_pin <= lvl;
    repeat ((gap < 4) ? 4 : gap) @(posedge clk);
  endtask : set_ext

  task automatic set_cap(input int ch, input logic lvl);
    @(posedge clk);
    if (ch == 1) begin
      capture_pin_one <= lvl;
    end else begin
      capture_pin_two <= lvl;
    end
    repeat (6) @(posedge clk);
  endtask : set_cap
endmodule : pin_model
